/* File: logic/cvs_pkg.sv */
// package: constants and types for the core voltage setpoint two-wire slave
package cvs_pkg;
  localparam logic [6:0] CVS_SLAVE_ADDR   = 7'h4C; // arbitrary slave address
  localparam logic [7:0] CVS_RESET_VALUE  = 8'h19; // slew 01, voltage 1001
  localparam int         CVS_VCODE_LSB    = 0;
  localparam int         CVS_VCODE_MSB    = 3;
  localparam int         CVS_SLEW_LSB     = 4;
  localparam int         CVS_SLEW_MSB     = 5;
  localparam logic [1:0] CVS_SLEW_5UA     = 2'h0;
  localparam logic [1:0] CVS_SLEW_10UA    = 2'h1;
  localparam logic [1:0] CVS_SLEW_24UA    = 2'h2;
  localparam logic [1:0] CVS_SLEW_47UA    = 2'h3;
  localparam logic [1:0] CVS_SLEW_FIXED   = CVS_SLEW_10UA;
  // setpoint in millivolts: base plus step times code
  localparam int         CVS_BASE_MV      = 850;
  localparam int         CVS_STEP_MV      = 50;
  // overvoltage persistence time and clock rate
  localparam int         CVS_OV_TIME_NS10 = 15;   // 1.5 us in units of 100 ns
  localparam int         CVS_CLK_MHZ      = 100;
  localparam int         CVS_OV_CYCLES    = CVS_OV_TIME_NS10 * CVS_CLK_MHZ / 10;
  localparam int         CVS_OVC_W        = 8;
  localparam logic [3:0] CVS_BIT_LAST     = 4'h7;
  localparam logic [3:0] CVS_BIT_ACK      = 4'h8;

  typedef enum logic [5:0] {
    CVS_IDLE  = 6'b000001,
    CVS_ADDR  = 6'b000010,
    CVS_WDATA = 6'b000100,
    CVS_RDATA = 6'b001000,
    CVS_ACK   = 6'b010000,
    CVS_RACK  = 6'b100000
  } cvs_state_t;

  typedef struct packed {
    logic [1:0] slew;
    logic [3:0] vcode;
  } cvs_setpoint_t;

  typedef struct packed {
    logic ov_above_114;
    logic ov_above_106;
    logic uv_below_86;
    logic uv_below_94;
  } cvs_cmp_t;
endpackage : cvs_pkg

/* File: logic/cvs_core.sv */
// module: two-wire slave, setpoint register and fault indicators
`timescale 1ns/1ps
module cvs_core #(
  parameter logic [6:0] SLAVE_ADDR = cvs_pkg::CVS_SLAVE_ADDR,
  parameter int         OV_CYCLES  = cvs_pkg::CVS_OV_CYCLES
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // two-wire bus pins, also voltage code bits 0 and 1
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  // pin strap and extra code pins
  input  wire logic                   code_source_select,
  input  wire logic [1:0]             voltage_code_hi,
  // regulator enable
  input  wire logic                   regulator_enable,
  // comparator inputs, analog side
  input  wire cvs_pkg::cvs_cmp_t      cmp,
  input  wire logic                   ldo_sram_ok,
  input  wire logic                   ldo_pll_ok,
  // outputs to analog side
  output cvs_pkg::cvs_setpoint_t      setpoint,
  output logic [10:0]                 setpoint_mv,
  output logic [3:0]                  ramp_source_sel,
  output logic                        phase_tristate,
  output logic                        overvoltage_fault,
  output logic                        undervoltage_fault,
  output logic                        outputs_in_tolerance,
  output logic                        outputs_in_tolerance_oe_n,
  output logic [7:0]                  voltage_slew_program
);

  function automatic logic [10:0] code_to_mv(input logic [3:0] code);
    code_to_mv = 11'(cvs_pkg::CVS_BASE_MV + cvs_pkg::CVS_STEP_MV * int'(code));
  endfunction : code_to_mv

  function automatic logic [3:0] slew_to_sel(input logic [1:0] s);
    case (s)
      cvs_pkg::CVS_SLEW_5UA:  slew_to_sel = 4'h1;
      cvs_pkg::CVS_SLEW_10UA: slew_to_sel = 4'h2;
      cvs_pkg::CVS_SLEW_24UA: slew_to_sel = 4'h4;
      default:                slew_to_sel = 4'h8;
    endcase
  endfunction : slew_to_sel

  // pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync;
  logic [1:0] vhi0_sync;
  logic [1:0] vhi1_sync;
  logic [3:0] cmp0_sync;
  logic [3:0] cmp1_sync;
  logic [1:0] ldo0_sync;
  logic [1:0] ldo1_sync;
  logic [1:0] en0_sync;
  logic       en_s;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      sel_sync  <= 2'h0;
      vhi0_sync <= 2'h0;
      vhi1_sync <= 2'h0;
      cmp0_sync <= 4'h0;
      cmp1_sync <= 4'h0;
      ldo0_sync <= 2'h0;
      ldo1_sync <= 2'h0;
      en0_sync  <= 2'h0;
      en_s      <= 1'b0;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
    end else begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      sel_sync  <= {sel_sync[0], code_source_select};
      vhi0_sync <= {vhi0_sync[0], voltage_code_hi[0]};
      vhi1_sync <= {vhi1_sync[0], voltage_code_hi[1]};
      cmp0_sync <= cmp;
      cmp1_sync <= cmp0_sync;
      ldo0_sync <= {ldo_sram_ok, ldo_pll_ok};
      ldo1_sync <= ldo0_sync;
      en0_sync  <= {en0_sync[0], regulator_enable};
      en_s      <= en0_sync[1];
      scl_d     <= scl_sync[1];
      sda_d     <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic bus_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign bus_mode  = ~sel_sync[1];
  assign scl_rise  = bus_mode & scl_s & ~scl_d;
  assign scl_fall  = bus_mode & ~scl_s & scl_d;
  assign start_det = bus_mode & scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = bus_mode & scl_s & scl_d & ~sda_d & sda_s;

  // bus state machine
  cvs_pkg::cvs_state_t state;
  logic [3:0]          bit_cnt;
  logic [7:0]          shreg;
  logic                is_read;
  logic [7:0]          prog;
  logic                ack_is_data;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state   <= cvs_pkg::CVS_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      is_read <= 1'b0;
    end else if (!bus_mode || stop_det) begin
      state   <= cvs_pkg::CVS_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_det) begin
      state   <= cvs_pkg::CVS_ADDR;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        cvs_pkg::CVS_ADDR: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == cvs_pkg::CVS_BIT_ACK) begin
            if (shreg[7:1] == SLAVE_ADDR) begin
              state   <= cvs_pkg::CVS_ACK;
              is_read <= shreg[0];
            end else begin
              state <= cvs_pkg::CVS_IDLE;
            end
            bit_cnt <= 4'h0;
          end
        end
        cvs_pkg::CVS_WDATA: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == cvs_pkg::CVS_BIT_ACK) begin
            state   <= cvs_pkg::CVS_ACK;
            bit_cnt <= 4'h0;
          end
        end
        cvs_pkg::CVS_ACK: begin
          if (scl_fall) begin
            state   <= is_read ? cvs_pkg::CVS_RDATA : cvs_pkg::CVS_WDATA;
            shreg   <= prog;
            bit_cnt <= 4'h0;
          end
        end
        cvs_pkg::CVS_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == cvs_pkg::CVS_BIT_LAST) begin
              state <= cvs_pkg::CVS_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
            end
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        cvs_pkg::CVS_RACK: begin
          if (scl_rise) begin
            is_read <= sda_s;
          end else if (scl_fall) begin
            state   <= is_read ? cvs_pkg::CVS_IDLE : cvs_pkg::CVS_RDATA;
            shreg   <= prog;
            bit_cnt <= 4'h0;
            if (!is_read) begin
              is_read <= 1'b1;
            end
          end
        end
        cvs_pkg::CVS_IDLE: begin
          bit_cnt <= 4'h0;
        end
        default: begin
          state <= cvs_pkg::CVS_IDLE;
        end
      endcase
    end
  end

  // pending acknowledge closes a data byte, not the address byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_is_data <= 1'b0;
    end else if (state == cvs_pkg::CVS_WDATA) begin
      ack_is_data <= 1'b1;
    end else if (state != cvs_pkg::CVS_ACK) begin
      ack_is_data <= 1'b0;
    end
  end

  // data line drive: low enable means driving
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      if (state == cvs_pkg::CVS_ACK) begin
        sda_oe_n <= 1'b0;
      end else if (state == cvs_pkg::CVS_RDATA) begin
        sda_oe_n <= shreg[7];
      end else begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // setpoint register, survives regulator enable low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prog <= cvs_pkg::CVS_RESET_VALUE;
    end else if (state == cvs_pkg::CVS_ACK && !is_read && scl_rise
                 && bus_mode && ack_is_data) begin
      prog <= shreg;
    end
  end

  // applied setpoint: bus register or pins
  logic [3:0] pin_code;
  assign pin_code = {vhi1_sync[1], vhi0_sync[1], sda_s, scl_s};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      setpoint        <= '{slew: cvs_pkg::CVS_RESET_VALUE[5:4],
                           vcode: cvs_pkg::CVS_RESET_VALUE[3:0]};
      setpoint_mv     <= code_to_mv(cvs_pkg::CVS_RESET_VALUE[3:0]);
      ramp_source_sel <= slew_to_sel(cvs_pkg::CVS_RESET_VALUE[5:4]);
    end else if (bus_mode) begin
      setpoint.vcode  <= prog[cvs_pkg::CVS_VCODE_MSB:cvs_pkg::CVS_VCODE_LSB];
      setpoint.slew   <= prog[cvs_pkg::CVS_SLEW_MSB:cvs_pkg::CVS_SLEW_LSB];
      setpoint_mv     <= code_to_mv(prog[cvs_pkg::CVS_VCODE_MSB:cvs_pkg::CVS_VCODE_LSB]);
      ramp_source_sel <= slew_to_sel(prog[cvs_pkg::CVS_SLEW_MSB:cvs_pkg::CVS_SLEW_LSB]);
    end else begin
      setpoint.vcode  <= pin_code;
      setpoint.slew   <= cvs_pkg::CVS_SLEW_FIXED;
      setpoint_mv     <= code_to_mv(pin_code);
      ramp_source_sel <= slew_to_sel(cvs_pkg::CVS_SLEW_FIXED);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      voltage_slew_program <= cvs_pkg::CVS_RESET_VALUE;
    end else begin
      voltage_slew_program <= prog;
    end
  end

  // overvoltage with persistence and hysteresis
  cvs_pkg::cvs_cmp_t          c;
  logic [cvs_pkg::CVS_OVC_W-1:0] ov_cnt;
  assign c = cmp1_sync;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ov_cnt            <= '0;
      overvoltage_fault <= 1'b0;
    end else if (overvoltage_fault) begin
      ov_cnt <= '0;
      if (!c.ov_above_106) begin
        overvoltage_fault <= 1'b0;
      end
    end else if (c.ov_above_114) begin
      if (ov_cnt >= cvs_pkg::CVS_OVC_W'(OV_CYCLES)) begin
        overvoltage_fault <= 1'b1;
      end else begin
        ov_cnt <= ov_cnt + 1'b1;
      end
    end else begin
      ov_cnt <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      undervoltage_fault <= 1'b0;
    end else if (c.uv_below_86) begin
      undervoltage_fault <= 1'b1;
    end else if (!c.uv_below_94) begin
      undervoltage_fault <= 1'b0;
    end
  end

  assign phase_tristate = overvoltage_fault | ~en_s;

  // tolerance indicator, open drain, follows faults
  logic all_in_reg;
  assign all_in_reg = en_s & ~overvoltage_fault & ~undervoltage_fault
                      & ldo1_sync[1] & ldo1_sync[0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outputs_in_tolerance      <= 1'b0;
      outputs_in_tolerance_oe_n <= 1'b0;
    end else begin
      outputs_in_tolerance      <= 1'b0;
      outputs_in_tolerance_oe_n <= all_in_reg;
    end
  end

endmodule : cvs_core

/* File: tb/cvs_core_properties.sv */
// checker: port-level properties of the setpoint two-wire slave
`timescale 1ns/1ps
module cvs_core_properties #(
  parameter int OV_CYCLES = 150
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   sys_rst,
  // watched inputs
  input wire logic                   code_source_select,
  input wire logic                   regulator_enable,
  input wire cvs_pkg::cvs_cmp_t      cmp,
  input wire logic                   ldo_sram_ok,
  input wire logic                   ldo_pll_ok,
  // watched outputs
  input wire logic                   sda_oe_n,
  input wire cvs_pkg::cvs_setpoint_t setpoint,
  input wire logic [10:0]            setpoint_mv,
  input wire logic [3:0]             ramp_source_sel,
  input wire logic                   phase_tristate,
  input wire logic                   overvoltage_fault,
  input wire logic                   undervoltage_fault,
  input wire logic                   outputs_in_tolerance_oe_n,
  input wire logic [7:0]             voltage_slew_program
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  int ov_run;
  // consecutive cycles with the raw overvoltage level high
  always_ff @(posedge clock) begin
    if (sys_rst || !cmp.ov_above_114) ov_run <= 0;
    else if (ov_run < OV_CYCLES + 20) ov_run <= ov_run + 1;
  end
  chk_reset_prog: assert property ($fell(sys_rst) |->
    voltage_slew_program == cvs_pkg::CVS_RESET_VALUE) else $error("reset value wrong");
  chk_ramp_select: assert property ($stable(setpoint)[*2] |->
    ramp_source_sel == 4'h1 << setpoint.slew) else $error("ramp select wrong");
  chk_code_mv: assert property ($stable(setpoint)[*2] |->
    setpoint_mv == 11'h352 + 11'h032 * setpoint.vcode) else $error("setpoint mv wrong");
  chk_ov_tristate: assert property (overvoltage_fault |-> phase_tristate)
    else $error("no tristate on overvoltage");
  chk_ov_early: assert property ($rose(overvoltage_fault) |-> ov_run >= OV_CYCLES)
    else $error("overvoltage too early");
  chk_ov_late: assert property (ov_run == OV_CYCLES + 10 |-> overvoltage_fault)
    else $error("overvoltage too late");
  chk_ov_clear: assert property ((!cmp.ov_above_106)[*5] |-> !overvoltage_fault)
    else $error("overvoltage not cleared");
  chk_uv_set: assert property (cmp.uv_below_86[*5] |-> undervoltage_fault)
    else $error("undervoltage not set");
  chk_uv_clear: assert property ((!cmp.uv_below_94)[*5] |-> !undervoltage_fault)
    else $error("undervoltage not cleared");
  chk_tol_good: assert property ((regulator_enable && ldo_sram_ok && ldo_pll_ok &&
    !overvoltage_fault && !undervoltage_fault)[*8] |-> outputs_in_tolerance_oe_n)
    else $error("tolerance not released");
  chk_pin_quiet: assert property (code_source_select[*6] |-> sda_oe_n)
    else $error("bus active in pin mode");
  chk_tol_off: assert property ((!regulator_enable)[*5] |-> !outputs_in_tolerance_oe_n)
    else $error("tolerance released while disabled");
endmodule : cvs_core_properties

bind cvs_core cvs_core_properties #(.OV_CYCLES(OV_CYCLES)) cvs_core_properties_i (
  .clock, .sys_rst, .code_source_select, .regulator_enable, .cmp, .ldo_sram_ok,
  .ldo_pll_ok, .sda_oe_n, .setpoint, .setpoint_mv, .ramp_source_sel, .phase_tristate,
  .overvoltage_fault, .undervoltage_fault, .outputs_in_tolerance_oe_n,
  .voltage_slew_program
);

/* File: tb/cvs_host_model.sv */
// partner: two-wire bus master driving the slave pins
`timescale 1ns/1ps
module cvs_host_model (
  // bus pins, 1 on sda_rel lets the pull-up win
  output logic      scl,
  output logic      sda_rel,
  // resolved data line
  input wire logic  sda_line
);
  int h = 40;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // pin mode: pins carry plain code bits
  task pins(input logic c, input logic d);
    scl = c;
    sda_rel = d;
  endtask : pins
  task start_cond();
    sda_rel = 1'b1;
    #(h / 2) scl = 1'b1;
    #(h) sda_rel = 1'b0;
    #(h) scl = 1'b0;
  endtask : start_cond
  task stop_cond();
    #(h / 2) sda_rel = 1'b0;
    #(h / 2) scl = 1'b1;
    #(h) sda_rel = 1'b1;
    #(h);
  endtask : stop_cond
  // one clock pulse, line sampled at the end of the high phase
  task bit_cyc(input logic d, output logic q);
    #(h / 2) sda_rel = d;
    #(h / 2) scl = 1'b1;
    #(h) q = sda_line;
    scl = 1'b0;
  endtask : bit_cyc
  // eight bits msb first, then the ninth clock
  task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
            output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(d[i], b);
      q[i] = b;
    end
    bit_cyc(ack_in, b);
    ack = !b;
  endtask : xfer
endmodule : cvs_host_model

/* File: tb/test_core_voltage_setpoint_i2c.sv */
// testbench: setpoint two-wire slave against a bus master model
`timescale 1ns/1ps
module test_core_voltage_setpoint_i2c;
  localparam logic [7:0] AW = {cvs_pkg::CVS_SLAVE_ADDR, 1'b0};
  logic                   clock;
  logic                   sys_rst;
  logic                   scl;
  logic                   sda_rel;
  logic                   sda_line;
  logic                   sda_out;
  logic                   sda_oe_n;
  logic                   code_source_select;
  logic [1:0]             voltage_code_hi;
  logic                   regulator_enable;
  cvs_pkg::cvs_cmp_t      cmp;
  logic                   ldo_sram_ok;
  logic                   ldo_pll_ok;
  cvs_pkg::cvs_setpoint_t setpoint;
  logic [10:0]            setpoint_mv;
  logic [3:0]             ramp_source_sel;
  logic                   phase_tristate;
  logic                   overvoltage_fault;
  logic                   undervoltage_fault;
  logic                   tol_oe_n;
  logic                   tol_out;
  logic [7:0]             voltage_slew_program;
  logic [7:0]             q;
  logic [7:0]             last;
  logic                   ack;
  int                     n;
  int                     error_cnt;
  int                     comparisons;
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  cvs_core cvs_core_i (
    .clock, .sys_rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n,
    .code_source_select, .voltage_code_hi, .regulator_enable, .cmp, .ldo_sram_ok,
    .ldo_pll_ok, .setpoint, .setpoint_mv, .ramp_source_sel, .phase_tristate,
    .overvoltage_fault, .undervoltage_fault, .outputs_in_tolerance(tol_out),
    .outputs_in_tolerance_oe_n(tol_oe_n), .voltage_slew_program
  );
  cvs_host_model cvs_host_model_i (.scl, .sda_rel, .sda_line);
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task wr(input int hp, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] pre;
    pre = voltage_slew_program;
    cvs_host_model_i.h = hp;
    cvs_host_model_i.start_cond();
    cvs_host_model_i.xfer(a, 1'b1, q, ack);
    check("addr ack", ack, a[7:1] == cvs_pkg::CVS_SLAVE_ADDR);
    check("no addr latch", voltage_slew_program, pre);
    cvs_host_model_i.xfer(d, 1'b1, q, ack);
    check("data ack", ack, a[7:1] == cvs_pkg::CVS_SLAVE_ADDR);
  endtask : wr
  task t_reset();
    check("reset prog", voltage_slew_program, 8'h19);
    check("reset ramp", ramp_source_sel, 4'h2);
    check("reset mv", setpoint_mv, 16'h514);
    check("tol value", tol_out, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task t_write();
    logic [3:0] v;
    logic [7:0] d;
    for (int s = 0; s < 4; s++) begin
      v = 4'(s * 4 + 2);
      wr(s[0] ? 40 : 100, AW, {2'h3, s[1:0], v});
      check("latched", voltage_slew_program, {2'h3, s[1:0], v});
      d = {s[1:0], 2'(3 - s), ~v};
      cvs_host_model_i.xfer(d, 1'b1, q, ack);
      check("second ack", ack, 1'b1);
      cvs_host_model_i.stop_cond();
      cyc(4);
      check("ramp", ramp_source_sel, 4'h1 << d[5:4]);
      check("vcode", setpoint.vcode, d[3:0]);
      check("mv", setpoint_mv, 16'h352 + 16'h32 * d[3:0]);
      last = d;
    end
    $display("write test done");
  endtask : t_write
  task t_read();
    cvs_host_model_i.start_cond();
    cvs_host_model_i.xfer(AW | 8'h01, 1'b1, q, ack);
    check("read addr ack", ack, 1'b1);
    cvs_host_model_i.xfer(8'hFF, 1'b0, q, ack);
    check("read data", q, last);
    cvs_host_model_i.xfer(8'hFF, 1'b1, q, ack);
    cvs_host_model_i.stop_cond();
    check("read again", q, last);
    $display("read test done");
  endtask : t_read
  task t_addr();
    wr(40, AW ^ 8'h02, 8'h35);
    cvs_host_model_i.stop_cond();
    cyc(4);
    check("foreign kept", voltage_slew_program, last);
    $display("address test done");
  endtask : t_addr
  task t_enable();
    regulator_enable = 1'b0;
    cyc(8);
    check("off tristate", phase_tristate, 1'b1);
    check("off tol", tol_oe_n, 1'b0);
    check("off kept", voltage_slew_program, last);
    regulator_enable = 1'b1;
    cyc(10);
    check("back setpoint", setpoint, last[5:0]);
    check("back tol", tol_oe_n, 1'b1);
    ldo_pll_ok = 1'b0;
    cyc(6);
    check("ldo tol", tol_oe_n, 1'b0);
    ldo_pll_ok = 1'b1;
    cyc(6);
    check("ldo tol back", tol_oe_n, 1'b1);
    $display("enable test done");
  endtask : t_enable
  task t_fault();
    cmp.ov_above_106 = 1'b1;
    cmp.ov_above_114 = 1'b1;
    cyc(100);
    cmp.ov_above_114 = 1'b0;
    cyc(6);
    check("short ov", overvoltage_fault, 1'b0);
    cmp.ov_above_114 = 1'b1;
    for (n = 0; n < 300 && overvoltage_fault !== 1'b1; n++) cyc(1);
    check("ov time", n >= cvs_pkg::CVS_OV_CYCLES && n <= 160, 1'b1);
    if (n == 300) end_of_test();
    cmp.ov_above_114 = 1'b0;
    cyc(8);
    check("ov held", overvoltage_fault, 1'b1);
    check("ov tristate", phase_tristate, 1'b1);
    check("ov tol", tol_oe_n, 1'b0);
    cmp.ov_above_106 = 1'b0;
    cyc(8);
    check("ov clear", overvoltage_fault, 1'b0);
    check("ov tol back", tol_oe_n, 1'b1);
    cmp.uv_below_94 = 1'b1;
    cyc(8);
    check("uv 94 only", undervoltage_fault, 1'b0);
    cmp.uv_below_86 = 1'b1;
    cyc(8);
    check("uv set", undervoltage_fault, 1'b1);
    cmp.uv_below_86 = 1'b0;
    cyc(8);
    check("uv held", {undervoltage_fault, tol_oe_n}, 2'h2);
    cmp.uv_below_94 = 1'b0;
    cyc(10);
    check("uv clear", {undervoltage_fault, tol_oe_n}, 2'h1);
    $display("fault test done");
  endtask : t_fault
  task t_pin();
    code_source_select = 1'b1;
    voltage_code_hi = 2'h3;
    cvs_host_model_i.pins(1'b0, 1'b1);
    cyc(10);
    check("pin setpoint", setpoint, 6'h1E);
    check("pin mv", setpoint_mv, 16'h60E);
    cvs_host_model_i.pins(1'b1, 1'b1);
    code_source_select = 1'b0;
    cyc(10);
    $display("pin test done");
  endtask : t_pin
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    code_source_select = 1'b0;
    voltage_code_hi = 2'h0;
    regulator_enable = 1'b1;
    cmp = '0;
    ldo_sram_ok = 1'b1;
    ldo_pll_ok = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clock);
    #1 sys_rst = 1'b0;
    cyc(6);
    t_reset();
    t_write();
    t_read();
    t_addr();
    t_enable();
    t_fault();
    t_pin();
    end_of_test();
  end
endmodule : test_core_voltage_setpoint_i2c
